// >>> design/ecu_cmd_unit.sv
// Command unit for error flag clearing and interrupt control
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module ecu_cmd_unit
    import ecu_pkg::*;
#(
    parameter int NUM_IRQ = 32,
    parameter int VEC_W   = 32
) (
    input  wire logic                 clock_in,
    input  wire logic                 reset_in,
    input  wire logic [7:0]           rx_byte_in,
    input  wire logic                 rx_valid_in,
    output logic                      rx_ready_out,
    input  wire logic                 standalone_in,
    input  wire logic [NUM_FLAGS-1:0] err_set_in,
    output logic      [NUM_FLAGS-1:0] err_flags_out,
    output logic      [NUM_IRQ-1:0]   irq_enable_out,
    output logic                      irq_global_en_out,
    output logic      [7:0]           tx_byte_out,
    output logic                      tx_valid_out,
    input  wire logic                 tx_ready_in,
    input  wire logic [7:0]           reg_addr_in,
    input  wire logic [31:0]          reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic      [31:0]          reg_rdata_out,
    output logic                      irq_out
);

    localparam int IDX_W = $clog2(NUM_IRQ);

    // ====================================================
    // Declarations
    ecu_state_t           state_ff;
    ecu_state_t           nxt_state;
    logic [3:0]           cnt_ff;
    logic [3:0]           nxt_cnt;
    logic [7:0]           sum_ff;
    logic [7:0]           nxt_sum;
    logic [7:0]           addr_ff;
    logic [7:0]           nxt_addr;
    logic [7:0]           instr_ff;
    logic [7:0]           nxt_instr;
    logic [7:0]           type_ff;
    logic [7:0]           nxt_type;
    logic [31:0]          value_ff;
    logic [31:0]          nxt_value;
    logic                 start_ff;
    logic                 nxt_start;
    logic [7:0]           rep_status_ff;
    logic [7:0]           nxt_rep_status;

    logic [NUM_FLAGS-1:0] err_ff;
    logic [NUM_FLAGS-1:0] nxt_err;
    logic [NUM_IRQ-1:0]   en_ff;
    logic [NUM_IRQ-1:0]   nxt_en;
    logic                 gen_ff;
    logic                 nxt_gen;
    logic [VEC_W-1:0]     irq_vector_define_cmd_mem     [NUM_IRQ];
    logic [VEC_W-1:0]     nxt_irq_vector_define_cmd_mem [NUM_IRQ];
    logic [NUM_EV-1:0]    ev_ff;
    logic [NUM_EV-1:0]    nxt_ev;
    logic [NUM_EV-1:0]    mask_ff;
    logic [NUM_EV-1:0]    nxt_mask;
    logic [7:0]           own_ff;
    logic [7:0]           nxt_own;
    logic [7:0]           host_ff;
    logic [7:0]           nxt_host;
    logic [IDX_W-1:0]     vsel_ff;
    logic [IDX_W-1:0]     nxt_vsel;
    logic [31:0]          rdata_ff;
    logic [31:0]          nxt_rdata;

    logic                 take;
    logic                 frame_end;
    logic                 addr_hit;
    logic                 sum_ok;
    logic                 exec_go;
    logic                 tx_done;
    logic                 num_ok;
    logic [IDX_W-1:0]     idx;
    logic [7:0]           cmd_status;
    logic [NUM_EV-1:0]    ev_set;
    logic [NUM_EV-1:0]    w1c;
    logic [NUM_FLAGS-1:0] clr;

    // ====================================================
    // Frame intake handshake and qualifiers
    assign rx_ready_out = (state_ff == ECU_RECV);
    assign take         = rx_valid_in && rx_ready_out;
    assign frame_end    = take && (cnt_ff == LAST_IDX);
    assign addr_hit     = (addr_ff == own_ff);
    assign sum_ok       = (rx_byte_in == sum_ff);
    assign num_ok       = {24'h000000, type_ff} < 32'(NUM_IRQ);
    assign idx          = type_ff[IDX_W-1:0];
    assign exec_go      = frame_end && addr_hit && (cmd_status == ST_OK);

    // ====================================================
    // Command check and reply status
    always_comb begin
        cmd_status = ST_OK;
        case (instr_ff)
            CMD_CLR_ERR: begin
                if (type_ff > CLR_SHUTDOWN) begin
                    cmd_status = ST_BAD_TYPE;
                end
            end
            CMD_IRQ_EN, CMD_IRQ_DIS: begin
                if (!num_ok && type_ff != IRQ_ALL) begin
                    cmd_status = ST_BAD_TYPE;
                end
            end
            CMD_IRQ_VECTOR_DEFINE_CMD: begin
                if (!standalone_in) begin
                    cmd_status = ST_BAD_MODE;
                end else if (!num_ok) begin
                    cmd_status = ST_BAD_TYPE;
                end
            end
            CMD_IRQ_RET: cmd_status = ST_OK;
            default:     cmd_status = ST_BAD_CMD;
        endcase
        if (!sum_ok) begin
            cmd_status = ST_BAD_SUM;
        end
    end

    // ====================================================
    // Frame collection and reply sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sum = sum_ff;
        nxt_addr = addr_ff;
        nxt_instr = instr_ff;
        nxt_type = type_ff;
        nxt_value = value_ff;
        nxt_start = 1'b0;
        nxt_rep_status = rep_status_ff;
        case (state_ff)
            ECU_RECV: begin
                if (take) begin
                    nxt_sum = add8(sum_ff, rx_byte_in);
                    nxt_cnt = 4'(cnt_ff + 4'h1);
                    case (cnt_ff)
                        4'h0: nxt_addr = rx_byte_in;
                        4'h1: nxt_instr = rx_byte_in;
                        4'h2: nxt_type = rx_byte_in;
                        4'h4, 4'h5, 4'h6, 4'h7: begin
                            nxt_value = {value_ff[23:0], rx_byte_in};
                        end
                        LAST_IDX: begin
                            nxt_cnt = 4'h0;
                            nxt_sum = 8'h00;
                            if (addr_hit) begin
                                nxt_state = ECU_REPLY;
                                nxt_start = 1'b1;
                                nxt_rep_status = cmd_status;
                            end
                        end
                        default: nxt_cnt = 4'(cnt_ff + 4'h1);
                    endcase
                end
            end
            ECU_REPLY: begin
                if (tx_done) begin
                    nxt_state = ECU_RECV;
                end
            end
            default: nxt_state = ECU_RECV;
        endcase
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= ECU_RECV;
            cnt_ff <= 4'h0;
            sum_ff <= 8'h00;
            addr_ff <= 8'h00;
            instr_ff <= 8'h00;
            type_ff <= 8'h00;
            value_ff <= 32'h00000000;
            start_ff <= 1'b0;
            rep_status_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sum_ff <= nxt_sum;
            addr_ff <= nxt_addr;
            instr_ff <= nxt_instr;
            type_ff <= nxt_type;
            value_ff <= nxt_value;
            start_ff <= nxt_start;
            rep_status_ff <= nxt_rep_status;
        end
    end

    // ====================================================
    // Reply serializer
    ecu_reply_tx u_reply (
        .clock_in     (clock_in),
        .reset_in     (reset_in),
        .start_in     (start_ff),
        .host_in      (host_ff),
        .own_in       (own_ff),
        .status_in    (rep_status_ff),
        .instr_in     (instr_ff),
        .value_in     (32'h00000000),
        .tx_ready_in  (tx_ready_in),
        .tx_byte_out  (tx_byte_out),
        .tx_valid_out (tx_valid_out),
        .done_out     (tx_done)
    );

    // ====================================================
    // Command effects, events and register file
    always_comb begin
        clr = '0;
        if (exec_go && instr_ff == CMD_CLR_ERR) begin
            clr = clear_mask(type_ff);
        end
        nxt_err = (err_ff & ~clr) | err_set_in;
        nxt_en = en_ff;
        nxt_gen = gen_ff;
        nxt_irq_vector_define_cmd_mem = irq_vector_define_cmd_mem;
        if (exec_go) begin
            case (instr_ff)
                CMD_IRQ_EN: begin
                    if (type_ff == IRQ_ALL) begin
                        nxt_gen = 1'b1;
                    end else begin
                        nxt_en[idx] = 1'b1;
                    end
                end
                CMD_IRQ_DIS: begin
                    if (type_ff == IRQ_ALL) begin
                        nxt_gen = 1'b0;
                    end else begin
                        nxt_en[idx] = 1'b0;
                    end
                end
                CMD_IRQ_VECTOR_DEFINE_CMD: nxt_irq_vector_define_cmd_mem[idx] = value_ff[VEC_W-1:0];
                default:  nxt_gen = gen_ff;
            endcase
        end
        ev_set = '0;
        ev_set[EV_DONE] = tx_done;
        ev_set[EV_SUM_ERR] = frame_end && addr_hit && !sum_ok;
        ev_set[EV_REFUSED] = frame_end && addr_hit && sum_ok && (cmd_status != ST_OK);
        ev_set[EV_FLAG] = |(err_set_in & ~err_ff);
        w1c = '0;
        if (reg_wr_in && reg_addr_in == REG_IRQ_STAT) begin
            w1c = reg_wdata_in[NUM_EV-1:0];
        end
        nxt_ev = (ev_ff & ~w1c) | ev_set;
        nxt_mask = mask_ff;
        nxt_own = own_ff;
        nxt_host = host_ff;
        nxt_vsel = vsel_ff;
        if (reg_wr_in) begin
            case (reg_addr_in)
                REG_IRQ_MASK: nxt_mask = reg_wdata_in[NUM_EV-1:0];
                REG_ADDRS: begin
                    nxt_own = reg_wdata_in[ADR_OWN_LSB +: 8];
                    nxt_host = reg_wdata_in[ADR_HOST_LSB +: 8];
                end
                REG_IRQ_VECTOR_DEFINE_CMD_SEL: nxt_vsel = reg_wdata_in[IDX_W-1:0];
                default:      nxt_vsel = vsel_ff;
            endcase
        end
        nxt_rdata = 32'h00000000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                REG_IRQ_STAT: nxt_rdata = 32'(ev_ff);
                REG_IRQ_MASK: nxt_rdata = 32'(mask_ff);
                REG_ERR_FLAG: nxt_rdata = 32'(err_ff);
                REG_IRQ_EN:   nxt_rdata = 32'(en_ff);
                REG_ADDRS: begin
                    nxt_rdata[ADR_OWN_LSB +: 8] = own_ff;
                    nxt_rdata[ADR_HOST_LSB +: 8] = host_ff;
                    nxt_rdata[ADR_GEN_BIT] = gen_ff;
                end
                REG_IRQ_VECTOR_DEFINE_CMD_SEL: nxt_rdata = 32'(vsel_ff);
                REG_IRQ_VECTOR_DEFINE_CMD_DAT: nxt_rdata = 32'(irq_vector_define_cmd_mem[vsel_ff]);
                default:      nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            err_ff <= '0;
            en_ff <= '0;
            gen_ff <= 1'b0;
            for (int i = 0; i < NUM_IRQ; i++) begin
                irq_vector_define_cmd_mem[i] <= '0;
            end
            ev_ff <= '0;
            mask_ff <= MASK_RST;
            own_ff <= OWN_ADDR_RST;
            host_ff <= HOST_ADR_RST;
            vsel_ff <= '0;
            rdata_ff <= 32'h00000000;
        end else begin
            err_ff <= nxt_err;
            en_ff <= nxt_en;
            gen_ff <= nxt_gen;
            irq_vector_define_cmd_mem <= nxt_irq_vector_define_cmd_mem;
            ev_ff <= nxt_ev;
            mask_ff <= nxt_mask;
            own_ff <= nxt_own;
            host_ff <= nxt_host;
            vsel_ff <= nxt_vsel;
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs
    assign err_flags_out     = err_ff;
    assign irq_enable_out    = en_ff;
    assign irq_global_en_out = gen_ff;
    assign reg_rdata_out     = rdata_ff;
    assign irq_out           = |(ev_ff & mask_ff);

    // ====================================================
    // Checks
    sequence s_hit_frame;
        frame_end && addr_hit;
    endsequence
    sequence s_reply_launch;
        start_ff ##1 tx_valid_out;
    endsequence

    property p_clear_one;
        @(posedge clock_in) disable iff (reset_in)
        exec_go && instr_ff == CMD_CLR_ERR && type_ff == CLR_TIMEOUT
            && !err_set_in[FLG_TIMEOUT]
            |=> !err_ff[FLG_TIMEOUT] && err_ff[FLG_ALARM]
                == ($past(err_ff[FLG_ALARM]) | $past(err_set_in[FLG_ALARM]));
    endproperty
    a_clear_one: assert property (p_clear_one)
        else $error("single flag clear wrong");

    property p_clear_all;
        @(posedge clock_in) disable iff (reset_in)
        exec_go && instr_ff == CMD_CLR_ERR && type_ff == CLR_ALL && err_set_in == '0
            |=> err_ff == '0;
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("clear all left a flag set");

    property p_set_wins;
        @(posedge clock_in) disable iff (reset_in)
        err_set_in[FLG_SHUTDOWN] |=> err_ff[FLG_SHUTDOWN];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag event lost against clear");

    property p_irq_en;
        @(posedge clock_in) disable iff (reset_in)
        exec_go && instr_ff == CMD_IRQ_EN && type_ff != IRQ_ALL
            |=> en_ff[$past(idx)] && gen_ff == $past(gen_ff);
    endproperty
    a_irq_en: assert property (p_irq_en)
        else $error("interrupt enable not set");

    property p_glob_en;
        @(posedge clock_in) disable iff (reset_in)
        exec_go && instr_ff == CMD_IRQ_EN && type_ff == IRQ_ALL
            |=> gen_ff && en_ff == $past(en_ff);
    endproperty
    a_glob_en: assert property (p_glob_en)
        else $error("global enable not set");

    property p_irq_dis;
        @(posedge clock_in) disable iff (reset_in)
        exec_go && instr_ff == CMD_IRQ_DIS && type_ff != IRQ_ALL
            |=> !en_ff[$past(idx)];
    endproperty
    a_irq_dis: assert property (p_irq_dis)
        else $error("interrupt enable not cleared");

    property p_glob_dis;
        @(posedge clock_in) disable iff (reset_in)
        exec_go && instr_ff == CMD_IRQ_DIS && type_ff == IRQ_ALL |=> !gen_ff;
    endproperty
    a_glob_dis: assert property (p_glob_dis)
        else $error("global enable not cleared");

    property p_irq_vector_define_cmd;
        @(posedge clock_in) disable iff (reset_in)
        exec_go && instr_ff == CMD_IRQ_VECTOR_DEFINE_CMD
            |=> irq_vector_define_cmd_mem[$past(idx)] == $past(value_ff[VEC_W-1:0]);
    endproperty
    a_irq_vector_define_cmd: assert property (p_irq_vector_define_cmd)
        else $error("vector entry not stored");

    property p_irq_vector_define_cmd_mode;
        @(posedge clock_in) disable iff (reset_in)
        s_hit_frame and (sum_ok && instr_ff == CMD_IRQ_VECTOR_DEFINE_CMD && !standalone_in)
            |=> rep_status_ff == ST_BAD_MODE;
    endproperty
    a_irq_vector_define_cmd_mode: assert property (p_irq_vector_define_cmd_mode)
        else $error("direct vector definition accepted");

    property p_reply;
        @(posedge clock_in) disable iff (reset_in)
        s_hit_frame |=> s_reply_launch;
    endproperty
    a_reply: assert property (p_reply)
        else $error("reply not launched after frame");

    property p_bad_sum;
        @(posedge clock_in) disable iff (reset_in)
        s_hit_frame and !sum_ok |=> rep_status_ff == ST_BAD_SUM && en_ff == $past(en_ff) [*1]
            ##0 ev_ff[EV_SUM_ERR];
    endproperty
    a_bad_sum: assert property (p_bad_sum)
        else $error("checksum error not reported");

endmodule

// >>> design/ecu_pkg.sv
// Constants, types and helpers for the error flag and interrupt command unit
// What this block does
// - Command 36 clears error flags chosen by type
// - Type 0 all; 1..5 one flag each
// - Command 25 enables the numbered interrupt
// - Number 255 sets the global interrupt enable
// - Command 26 disables the numbered interrupt
// - Number 255 clears the global interrupt enable
// - Command 37 stores handler address per interrupt, in standalone mode only
// - Redefining a vector replaces the old address
// - Reply: host, own, status, instruction, value, checksum
package ecu_pkg;

    // ====================================================
    // Instruction codes and special numbers
    localparam logic [7:0] CMD_IRQ_EN   = 8'h19;
    localparam logic [7:0] CMD_IRQ_DIS  = 8'h1A;
    localparam logic [7:0] CMD_CLR_ERR  = 8'h24;
    localparam logic [7:0] CMD_IRQ_VECTOR_DEFINE_CMD     = 8'h25;
    localparam logic [7:0] CMD_IRQ_RET  = 8'h26;
    localparam logic [7:0] IRQ_ALL      = 8'hFF;

    // ====================================================
    // Clear-error type codes and flag bit positions
    localparam logic [7:0] CLR_ALL      = 8'h00;
    localparam logic [7:0] CLR_TIMEOUT  = 8'h01;
    localparam logic [7:0] CLR_ALARM    = 8'h02;
    localparam logic [7:0] CLR_DEVIATE  = 8'h03;
    localparam logic [7:0] CLR_POSITION = 8'h04;
    localparam logic [7:0] CLR_SHUTDOWN = 8'h05;
    localparam int         FLG_TIMEOUT  = 0;
    localparam int         FLG_ALARM    = 1;
    localparam int         FLG_DEVIATE  = 2;
    localparam int         FLG_POSITION = 3;
    localparam int         FLG_SHUTDOWN = 4;
    localparam int         NUM_FLAGS    = 5;

    // ====================================================
    // Reply status codes and frame layout
    localparam logic [7:0] ST_OK        = 8'h64;
    localparam logic [7:0] ST_BAD_SUM   = 8'h01;
    localparam logic [7:0] ST_BAD_CMD   = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
    localparam logic [7:0] ST_BAD_MODE  = 8'h06;
    localparam logic [3:0] LAST_IDX     = 4'h8;
    localparam logic [3:0] FRAME_BYTES  = 4'h9;

    // ====================================================
    // Register offsets, fields and reset values
    localparam logic [7:0] REG_IRQ_STAT = 8'h00;
    localparam logic [7:0] REG_IRQ_MASK = 8'h04;
    localparam logic [7:0] REG_ERR_FLAG = 8'h08;
    localparam logic [7:0] REG_IRQ_EN   = 8'h0C;
    localparam logic [7:0] REG_ADDRS    = 8'h10;
    localparam logic [7:0] REG_IRQ_VECTOR_DEFINE_CMD_SEL = 8'h14;
    localparam logic [7:0] REG_IRQ_VECTOR_DEFINE_CMD_DAT = 8'h18;
    localparam int         ADR_OWN_LSB  = 0;
    localparam int         ADR_HOST_LSB = 8;
    localparam int         ADR_GEN_BIT  = 16;
    localparam logic [7:0] OWN_ADDR_RST = 8'h01;
    localparam logic [7:0] HOST_ADR_RST = 8'h02;
    localparam logic [3:0] MASK_RST     = 4'h0;

    // ====================================================
    // Interrupt event bits
    localparam int EV_DONE    = 0;
    localparam int EV_SUM_ERR = 1;
    localparam int EV_REFUSED = 2;
    localparam int EV_FLAG    = 3;
    localparam int NUM_EV     = 4;

    typedef enum logic {ECU_RECV, ECU_REPLY} ecu_state_t;

    // Modulo-256 byte sum
    function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
        add8 = 8'(a + b);
    endfunction

    // Flag bits hit by a clear-error type code
    function automatic logic [NUM_FLAGS-1:0] clear_mask(input logic [7:0] t);
        clear_mask = '0;
        case (t)
            CLR_ALL:      clear_mask = '1;
            CLR_TIMEOUT:  clear_mask[FLG_TIMEOUT] = 1'b1;
            CLR_ALARM:    clear_mask[FLG_ALARM] = 1'b1;
            CLR_DEVIATE:  clear_mask[FLG_DEVIATE] = 1'b1;
            CLR_POSITION: clear_mask[FLG_POSITION] = 1'b1;
            CLR_SHUTDOWN: clear_mask[FLG_SHUTDOWN] = 1'b1;
            default:      clear_mask = '0;
        endcase
    endfunction

endpackage

// >>> design/ecu_reply_tx.sv
// Reply frame builder and byte serializer
`timescale 1ns/1ps
module ecu_reply_tx
    import ecu_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        start_in,
    input  wire logic [7:0]  host_in,
    input  wire logic [7:0]  own_in,
    input  wire logic [7:0]  status_in,
    input  wire logic [7:0]  instr_in,
    input  wire logic [31:0] value_in,
    input  wire logic        tx_ready_in,
    output logic      [7:0]  tx_byte_out,
    output logic             tx_valid_out,
    output logic             done_out
);

    logic [7:0] buf_ff     [9];
    logic [7:0] nxt_buf    [9];
    logic [3:0] left_ff;
    logic [3:0] nxt_left;

    // ====================================================
    // Load, checksum and shift
    always_comb begin
        logic [7:0] sum;
        sum = 8'h00;
        nxt_buf = buf_ff;
        nxt_left = left_ff;
        if (start_in) begin
            nxt_buf[0] = host_in;
            nxt_buf[1] = own_in;
            nxt_buf[2] = status_in;
            nxt_buf[3] = instr_in;
            nxt_buf[4] = value_in[31:24];
            nxt_buf[5] = value_in[23:16];
            nxt_buf[6] = value_in[15:8];
            nxt_buf[7] = value_in[7:0];
            for (int i = 0; i < 8; i++) begin
                sum = add8(sum, nxt_buf[i]);
            end
            nxt_buf[8] = sum;
            nxt_left = FRAME_BYTES;
        end else if (left_ff != 4'h0 && tx_ready_in) begin
            for (int i = 0; i < 8; i++) begin
                nxt_buf[i] = buf_ff[i+1];
            end
            nxt_left = 4'(left_ff - 4'h1);
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            for (int i = 0; i < 9; i++) begin
                buf_ff[i] <= 8'h00;
            end
            left_ff <= 4'h0;
        end else begin
            buf_ff <= nxt_buf;
            left_ff <= nxt_left;
        end
    end

    // Handshake and head byte
    assign tx_byte_out  = buf_ff[0];
    assign tx_valid_out = (left_ff != 4'h0);
    assign done_out     = (left_ff == 4'h1) && tx_ready_in;

    property p_reply_head;
        @(posedge clock_in) disable iff (reset_in)
        start_in |=> tx_valid_out && tx_byte_out == $past(host_in)
            && buf_ff[2] == $past(status_in) && buf_ff[3] == $past(instr_in);
    endproperty
    a_reply_head: assert property (p_reply_head)
        else $error("reply frame head not loaded");

endmodule

// >>> dv/ecu_cmd_unit_tb_top.sv
// Self-checking bench for the command unit
`timescale 1ns/1ps
module ecu_cmd_unit_tb_top
    import ecu_pkg::*;
;
    logic        clock_in = 0;
    logic        reset_in = 1;
    logic        rx_v = 0, sa = 0, wr = 0, rd = 0, stall = 0;
    logic        rdy, got, txv, rxr, irq, gen;
    logic [7:0]  rxb = 0, adr = 0, txb, n;
    logic [4:0]  eset = 0, flg;
    logic [31:0] wd = 0, rdat, en, rnd = 32'hAEFC, vv;
    logic [7:0]  exp_q[$];
    int          err_count = 0, checks_done = 0;
    ecu_cmd_unit u_ecu_cmd_unit (.clock_in(clock_in), .reset_in(reset_in),
        .rx_byte_in(rxb), .rx_valid_in(rx_v), .rx_ready_out(rxr), .standalone_in(sa),
        .err_set_in(eset), .err_flags_out(flg), .irq_enable_out(en),
        .irq_global_en_out(gen), .tx_byte_out(txb), .tx_valid_out(txv),
        .tx_ready_in(rdy), .reg_addr_in(adr), .reg_wdata_in(wd), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdat), .irq_out(irq));
    ecu_host_model u_ecu_host_model (.stall_in(stall), .tx_valid_in(txv),
        .tx_ready_out(rdy), .got_out(got));
    initial begin
        forever #4 clock_in = ~clock_in;
    end
    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Random stall pattern from the shift register
    always @(posedge clock_in) begin
        rnd   <= lfsr_next(rnd);
        stall <= rnd[0];
    end
    task automatic conclude();
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Watcher: each reply byte against the oldest note
    always @(posedge clock_in) begin
        if (!reset_in && got) begin
            chk({24'h0, txb}, exp_q.size() ? {24'h0, exp_q[0]} : 32'hFFFF);
            if (exp_q.size()) exp_q.pop_front();
        end
    end
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr <= 1; adr <= a; wd <= d;
        @(posedge clock_in);
        wr <= 0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_in);
        rd <= 1; adr <= a;
        @(posedge clock_in);
        rd <= 0;
        #1 chk(rdat, e);
    endtask
    // Sends one frame, notes the reply and waits for it
    task automatic frame(input logic [7:0] i, t, input logic [31:0] v,
                         input logic [7:0] st, input logic s, input logic bad);
        logic [7:0] b[9];
        int k;
        b = '{8'h01, i, t, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        for (k = 0; k < 8; k++) b[8] = 8'(b[8] + b[k]);
        b[8] = b[8] ^ {7'h0, bad};
        exp_q = {8'h02, 8'h01, st, i, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (k = 0; k < 8; k++) exp_q[8] = 8'(exp_q[8] + exp_q[k]);
        for (k = 0; k < 9; k++) begin
            @(posedge clock_in);
            rx_v <= 1; rxb <= b[k]; sa <= s;
        end
        @(posedge clock_in);
        rx_v <= 0;
        for (k = 0; k < 300 && (exp_q.size() || !rxr); k++) @(posedge clock_in);
        if (k == 300) begin
            err_count++;
            conclude();
        end
    endtask
    initial begin
        repeat (5) @(posedge clock_in);
        reset_in <= 0;
        reg_rd(REG_IRQ_MASK, 0);
        reg_wr(REG_IRQ_MASK, 32'h1);
        for (int t = 0; t < 6; t++) begin
            @(posedge clock_in) eset <= 5'h1F;
            @(posedge clock_in) eset <= 5'h00;
            frame(CMD_CLR_ERR, 8'(t), 0, ST_OK, 0, 0);
            chk(flg, t ? 5'h1F & ~(5'h1 << (t - 1)) : 5'h0);
        end
        reg_rd(REG_ERR_FLAG, 32'h0F);
        frame(CMD_CLR_ERR, 8'h06, 0, ST_BAD_TYPE, 0, 0);
        n = {3'h0, rnd[4:0]};
        frame(CMD_IRQ_EN, n, 0, ST_OK, 0, 0);
        chk(en[n], 1);
        frame(CMD_IRQ_EN, IRQ_ALL, 0, ST_OK, 0, 0);
        chk(gen, 1);
        frame(CMD_IRQ_DIS, n, 0, ST_OK, 0, 0);
        chk(en, 0);
        frame(CMD_IRQ_DIS, IRQ_ALL, 0, ST_OK, 0, 0);
        chk(gen, 0);
        reg_wr(REG_IRQ_VECTOR_DEFINE_CMD_SEL, {24'h0, n});
        frame(CMD_IRQ_VECTOR_DEFINE_CMD, n, 32'h32, ST_OK, 1, 0);
        vv = rnd;
        frame(CMD_IRQ_VECTOR_DEFINE_CMD, n, vv, ST_OK, 1, 0);
        frame(CMD_IRQ_VECTOR_DEFINE_CMD, n, 32'h5, ST_BAD_MODE, 0, 0);
        reg_rd(REG_IRQ_VECTOR_DEFINE_CMD_DAT, vv);
        frame(CMD_IRQ_RET, IRQ_ALL, 0, ST_OK, 1, 0);
        frame(CMD_IRQ_EN, 8'h20, 0, ST_BAD_TYPE, 0, 0);
        frame(8'h27, 8'h00, 0, ST_BAD_CMD, 0, 0);
        frame(CMD_IRQ_EN, 8'h01, 0, ST_BAD_SUM, 0, 1);
        chk(en, 0);
        #1 chk(irq, 1);
        reg_rd(REG_IRQ_STAT, 32'hF);
        reg_rd(REG_ADDRS, 32'h201);
        reg_wr(REG_IRQ_STAT, 32'hF);
        #1 chk(irq, 0);
        reg_rd(8'h40, 0);
        conclude();
    end
endmodule

// >>> dv/ecu_host_model.sv
// Host side model that takes reply bytes, stalling on request
`timescale 1ns/1ps
module ecu_host_model (
    input  wire logic stall_in,
    input  wire logic tx_valid_in,
    output logic      tx_ready_out,
    output logic      got_out
);
    // Ready unless stalled; a byte counts when both are high
    assign tx_ready_out = ~stall_in;
    assign got_out      = tx_valid_in & tx_ready_out;
endmodule
